// [core/kds_fifo.v]
// eight-entry first-in first-out store for key codes
// assumes one clock, asynchronous active-low reset
`include "kds_regs.vh"

module kds_fifo
(
  input  wire       ref_clk_in,
  input  wire       arst_n_in,
  input  wire       push_in,
  input  wire [5:0] data_in,
  input  wire       pop_in,
  output wire [5:0] data_out,
  output wire       empty_out,
  output wire       overflow_out
);

  reg  [5:0]              mem [0:`KDS_FIFO_DEPTH-1];
  reg  [`KDS_SLOT_W-1:0]  rd_ptr;
  reg  [`KDS_SLOT_W-1:0]  wr_ptr;
  reg  [`KDS_CNT_W-1:0]   count;
  wire                    full;
  wire                    do_pop;
  wire                    clear;

  assign full         = (count == `KDS_FIFO_DEPTH);
  assign empty_out    = (count == 4'h0);
  assign do_pop       = pop_in && !empty_out;
  // push into a full store with no read: wipe it
  assign clear        = push_in && full && !pop_in;
  assign overflow_out = clear;
  assign data_out     = mem[rd_ptr]; // oldest first

  always @(posedge ref_clk_in)
  begin
    if (push_in && !clear)
      mem[wr_ptr] <= data_in;
  end

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_ptr <= 3'h0;
      wr_ptr <= 3'h0;
      count  <= 4'h0;
    end
    else if (clear)
    begin
      rd_ptr <= 3'h0;
      wr_ptr <= 3'h0;
      count  <= 4'h0;
    end
    else
    begin
      if (push_in)
        wr_ptr <= wr_ptr + 3'h1;
      if (do_pop)
        rd_ptr <= rd_ptr + 3'h1;
      if (push_in && !do_pop)
        count <= count + 4'h1;
      else if (do_pop && !push_in)
        count <= count - 4'h1;
    end
  end

endmodule

// [core/kds_regs.vh]
// constants for the keyboard and display scan interface
// assumes a 40 MHz system clock and an 8-bit host i/o bus
`ifndef KDS_REGS_VH
`define KDS_REGS_VH

// ****************************************************************
// timing
// ****************************************************************
`define KDS_CLK_HZ        40000000
`define KDS_SLOT_TIME_US  1000
`define KDS_SLOT_CYCLES   ((`KDS_CLK_HZ / 1000000) * `KDS_SLOT_TIME_US)
`define KDS_PRESC_W       16

// ****************************************************************
// scan geometry
// ****************************************************************
`define KDS_SLOTS         8
`define KDS_KEY_ROWS      5
`define KDS_COLS          8
`define KDS_FIFO_DEPTH    8
`define KDS_SLOT_W        3
`define KDS_CNT_W         4
`define KDS_COL_W         3

// ****************************************************************
// display word layout
// ****************************************************************
`define KDS_SEG_W         7
`define KDS_DP_BIT        7
`define KDS_SLOT_LAST     3'h7

// ****************************************************************
// host address: 3 bits pick the ram slot on write; reads always return the key store
// ****************************************************************
`define KDS_KEY_VALID_BIT 7

`endif

// [core/kds_scan.v]
// keyboard and led display scan interface on the host i/o bus
// assumes host strobes synchronous to ref_clk_in, one clock domain
`include "kds_regs.vh"

module kds_scan
(
  input  wire       ref_clk_in,
  input  wire       arst_n_in,
  input  wire       io_request_strobe_n_in,
  input  wire       rd_n_in,
  input  wire       wr_n_in,
  input  wire       cs_n_in,
  input  wire [2:0] addr_in,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_n_out,
  input  wire [7:0] key_col_n_in,
  output reg  [2:0] row_sel_out,
  output reg  [6:0] seg_code_out,
  output reg        dp_out,
  output reg  [4:0] key_row_n_out,
  output reg        key_overflow_out
);

  // ****************************************************************
  // host access decode
  // ****************************************************************
  wire sel;
  wire rd_access;
  wire wr_access;
  reg  rd_access_d;

  assign sel       = !io_request_strobe_n_in && !cs_n_in;
  assign rd_access = sel && !rd_n_in;
  assign wr_access = sel && !wr_n_in;

  // ****************************************************************
  // output ram, one word per scan slot
  // ****************************************************************
  reg [7:0] out_ram [0:`KDS_SLOTS-1];

  always @(posedge ref_clk_in)
  begin
    if (wr_access)
      out_ram[addr_in] <= data_in;
  end

  // ****************************************************************
  // scan prescaler and slot counter
  // ****************************************************************
  reg [`KDS_PRESC_W-1:0] presc;
  reg [`KDS_SLOT_W-1:0]  slot;
  wire                   tick;

  assign tick = (presc == `KDS_SLOT_CYCLES - 1);

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      presc <= 16'h0000;
      slot  <= 3'h0;
    end
    else if (tick)
    begin
      presc <= 16'h0000;
      slot  <= slot + 3'h1;
    end
    else
      presc <= presc + 16'h0001;
  end

  // ****************************************************************
  // display drive, registered per slot
  // ****************************************************************
  wire [7:0] slot_word;

  assign slot_word = out_ram[slot];

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      row_sel_out   <= 3'h0;
      seg_code_out  <= 7'h00;
      dp_out        <= 1'b0;
      key_row_n_out <= 5'h1F;
    end
    else
    begin
      // one slot of eight, about 12.5 percent each
      row_sel_out  <= slot;
      // pattern follows the selected cathode
      seg_code_out <= slot_word[`KDS_SEG_W-1:0];
      // slots 0-3 digits, 4 sign digit
      dp_out       <= slot_word[`KDS_DP_BIT];
      if (slot < `KDS_KEY_ROWS)
        key_row_n_out <= ~(5'h01 << slot);
      else
        key_row_n_out <= 5'h1F;
    end
  end

  // ****************************************************************
  // key capture with per-row held memory
  // ****************************************************************
  reg  [`KDS_COLS-1:0] held [0:`KDS_KEY_ROWS-1];
  reg  [2:0]           col_idx;
  reg                  col_hit;
  reg                  push;
  reg  [5:0]           push_code;
  reg  [2:0]           cap_row;
  wire                 key_row_slot;
  wire [7:0]           cols;
  integer              i;

  assign cols         = ~key_col_n_in;
  assign key_row_slot = (row_sel_out < `KDS_KEY_ROWS);

  always @*
  begin
    col_idx = 3'h0;
    col_hit = 1'b0;
    for (i = `KDS_COLS - 1; i >= 0; i = i - 1)
    begin
      if (cols[i])
      begin
        col_idx = i[2:0];
        col_hit = 1'b1;
      end
    end
  end

  // sample near slot end so rows have settled
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      push      <= 1'b0;
      push_code <= 6'h00;
      cap_row   <= 3'h0;
      for (i = 0; i < `KDS_KEY_ROWS; i = i + 1)
        held[i] <= 8'h00;
    end
    else
    begin
      push    <= 1'b0;
      cap_row <= row_sel_out;
      if (tick && key_row_slot)
      begin
        held[row_sel_out] <= cols;
        // new press only, not while held
        if (col_hit && !held[row_sel_out][col_idx])
        begin
          push      <= 1'b1;
          push_code <= {row_sel_out, col_idx};
        end
      end
    end
  end

  // ****************************************************************
  // key store and host read
  // ****************************************************************
  wire [5:0] fifo_data;
  wire       fifo_empty;
  wire       fifo_ovf;
  wire       pop;

  assign pop = rd_access && !rd_access_d;

  kds_fifo u_fifo
  (
    .ref_clk_in   (ref_clk_in),
    .arst_n_in    (arst_n_in),
    .push_in      (push),
    .data_in      (push_code),
    .pop_in       (pop),
    .data_out     (fifo_data),
    .empty_out    (fifo_empty),
    .overflow_out (fifo_ovf)
  );

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_access_d      <= 1'b0;
      data_out         <= 8'h00;
      data_oe_n_out    <= 1'b1;
      key_overflow_out <= 1'b0;
    end
    else
    begin
      rd_access_d      <= rd_access;
      key_overflow_out <= fifo_ovf;
      data_oe_n_out    <= !rd_access;
      if (pop)
        // valid flag in bit 7, code below
        data_out <= {!fifo_empty, 1'b0, fifo_data};
    end
  end

endmodule

// [tb/kds_host.sv]
// host bus model: i/o request, read and write strobes, select
// assumes the bench calls its tasks, clock shared with the block
module kds_host
(
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rd_data_in,
  output logic            io_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            cs_n_out,
  output logic [2:0]      addr_out,
  output logic [7:0]      wr_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {io_n_out, rd_n_out, wr_n_out, cs_n_out} = 4'hF;
    addr_out = 3'h0;
    wr_data_out = 8'h00;
  end
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #2;
    addr_out = a;
    wr_data_out = d;
    {io_n_out, cs_n_out, wr_n_out} = 3'h0;
    @(posedge ref_clk_in);
    #2;
    {io_n_out, cs_n_out, wr_n_out} = 3'h7;
    wr_data_out = ~d; // no stale value after release
  endtask
  task automatic bus_read(output logic [7:0] d);
    @(posedge ref_clk_in);
    #2;
    {io_n_out, cs_n_out, rd_n_out} = 3'h0;
    @(posedge ref_clk_in);
    #2;
    {io_n_out, cs_n_out, rd_n_out} = 3'h7;
    @(posedge ref_clk_in);
    #1;
    d = rd_data_in;
  endtask
endmodule

// [tb/kds_scan_checker.sv]
// checker: bus and scan relations at the scan block's ports
// assumes bind into kds_scan, one clock domain
module kds_scan_checker
(
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  input wire logic       io_request_strobe_n_in,
  input wire logic       rd_n_in,
  input wire logic       wr_n_in,
  input wire logic       cs_n_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n_out,
  input wire logic [2:0] row_sel_out,
  input wire logic [6:0] seg_code_out,
  input wire logic       dp_out,
  input wire logic [4:0] key_row_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire sel    = !io_request_strobe_n_in && !cs_n_in;
  wire rd_acc = sel && !rd_n_in;
  wire wr_acc = sel && !wr_n_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  bus_drive_a: assert property (rd_acc |=> !data_oe_n_out)
    else $error("bus not driven after read");
  bus_release_a: assert property
    (!rd_acc && !$past(rd_acc) |=> data_oe_n_out)
    else $error("bus driven without read");
  read_update_a: assert property
    ($changed(data_out) |-> $past(rd_acc))
    else $error("read data changed without read");
  spare_bit_a: assert property
    (!data_oe_n_out |-> !data_out[6])
    else $error("unused read bit set");
  row_strobe_a: assert property
    ($past(arst_n_in) |-> key_row_n_out ==
    (row_sel_out < 3'h5 ? ~(5'h01 << row_sel_out) : 5'h1F))
    else $error("row strobe does not match slot");
  row_order_a: assert property
    ($changed(row_sel_out) |-> row_sel_out == $past(row_sel_out) + 3'h1)
    else $error("slot code skipped");
  slot_hold_a: assert property
    ($changed(row_sel_out) |=> $stable(row_sel_out) [*8])
    else $error("slot too short");
  seg_source_a: assert property
    ($past(arst_n_in, 2) &&
    $changed({dp_out, seg_code_out}) |-> $changed(row_sel_out) ||
    $past(wr_acc) || $past(wr_acc, 2))
    else $error("segments changed inside a slot");
  rd_c: cover property (rd_acc);
  wr_c: cover property (wr_acc);
  slot_c: cover property ($changed(row_sel_out));
endmodule
bind kds_scan kds_scan_checker kds_scan_checker_inst
(
  .ref_clk_in, .arst_n_in, .io_request_strobe_n_in, .rd_n_in, .wr_n_in,
  .cs_n_in, .data_out, .data_oe_n_out, .row_sel_out, .seg_code_out,
  .dp_out, .key_row_n_out
);

// [tb/kds_scan_test.sv]
// self-checking bench for the scan block with a host bus model
// assumes the full 40000-cycle slot, 40 MHz clock
module kds_scan_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk       = 1'b0;
  logic       arst_n    = 1'b0;
  logic [7:0] key_col_n = 8'hFF;
  wire        io_n, rd_n, wr_n, cs_n, oe_n, dp, ovf;
  wire  [2:0] addr, row_sel;
  wire  [7:0] wdata, rdata;
  wire  [6:0] seg;
  wire  [4:0] key_row_n;
  int         err_total = 0;
  int         tests_run = 0;
  always #12.5 clk = ~clk;
  kds_scan kds_scan_inst
  (
    .ref_clk_in(clk), .arst_n_in(arst_n), .io_request_strobe_n_in(io_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .cs_n_in(cs_n), .addr_in(addr),
    .data_in(wdata), .data_out(rdata), .data_oe_n_out(oe_n),
    .key_col_n_in(key_col_n), .row_sel_out(row_sel), .seg_code_out(seg),
    .dp_out(dp), .key_row_n_out(key_row_n), .key_overflow_out(ovf)
  );
  kds_host kds_host_inst
  (
    .ref_clk_in(clk), .rd_data_in(rdata), .io_n_out(io_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .cs_n_out(cs_n), .addr_out(addr), .wr_data_out(wdata)
  );
  task automatic chk(input string nm, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic t_display;
    kds_host_inst.bus_write(3'h0, 8'h85);
    kds_host_inst.bus_write(3'h1, 8'h3A);
    repeat (2) @(posedge clk);
    #1;
    chk("slot", 8'h00, {5'h00, row_sel});
    chk("segments", 8'h05, {1'b0, seg});
    chk("point", 8'h01, {7'h00, dp});
    chk("row strobe", 8'h1E, {3'h0, key_row_n});
    $display("test display done");
  endtask
  task automatic t_empty;
    logic [7:0] d;
    kds_host_inst.bus_read(d);
    chk("empty valid", 8'h00, {d[7], 7'h00});
    $display("test empty read done");
  endtask
  task automatic t_key;
    int         n;
    logic [7:0] d;
    @(posedge clk);
    #2;
    key_col_n = 8'hF7;
    for (n = 0; n < 41000 && row_sel !== 3'h1; n++)
      @(posedge clk);
    #1;
    chk("next slot", 8'h01, {5'h00, row_sel});
    chk("segments", 8'h3A, {1'b0, seg});
    chk("point", 8'h00, {7'h00, dp});
    chk("row strobe", 8'h1D, {3'h0, key_row_n});
    kds_host_inst.bus_read(d);
    chk("key code", 8'h83, d);
    kds_host_inst.bus_read(d);
    chk("drained valid", 8'h00, {d[7], 7'h00});
    chk("no overflow", 8'h00, {7'h00, ovf});
    @(posedge clk);
    #2;
    key_col_n = 8'hFF;
    $display("test key capture done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    arst_n = 1'b1;
    t_display;
    t_empty;
    t_key;
    complete_run;
  end
endmodule
